// ### design/deep_sleep_gate_consts.vh
// Constants for the deep-sleep clock gating register block.
`ifndef DEEP_SLEEP_GATE_CONSTS_VH
`define DEEP_SLEEP_GATE_CONSTS_VH

`define ADDR_W 12
`define DATA_W 32
`define UNIT_N 10
`define UNIT_IDX_W 4

`define OFS_DEEP_SLEEP_GATE_1 12'h124
`define OFS_IRQ_STATUS 12'h180
`define OFS_IRQ_MASK 12'h184
`define OFS_FAULT_INFO 12'h188

`define DEEP_SLEEP_GATE_1_RESET 32'h00000000
`define DEEP_SLEEP_GATE_1_WMASK 32'h070f0013
`define IRQ_MASK_RESET 3'h0
`define IRQ_STATUS_RESET 3'h0
`define IRQ_W 3
`define READ_ZERO 32'h00000000

`define BIT_ASYNC_SERIAL_0 0
`define BIT_ASYNC_SERIAL_1 1
`define BIT_SYNC_SERIAL_0 4
`define BIT_GP_COUNTER_0 16
`define BIT_GP_COUNTER_1 17
`define BIT_GP_COUNTER_2 18
`define BIT_GP_COUNTER_3 19
`define BIT_COMPARATOR_0 24
`define BIT_COMPARATOR_1 25
`define BIT_COMPARATOR_2 26

`define IRQ_BUS_FAULT 0
`define IRQ_DEEP_ENTER 1
`define IRQ_DEEP_EXIT 2

`define MODE_RUN 2'h0
`define MODE_SLEEP 2'h1
`define MODE_DEEP 2'h2

`define FAULT_COUNT_W 8
`define FAULT_IDX_LSB 0
`define FAULT_COUNT_LSB 8
`define FAULT_WRITE_BIT 16

`endif

// ### design/unit_clock_gate.v
// Glitch-free clock gate for one peripheral unit.
`timescale 1ns/10ps
module unit_clock_gate (
	clk,
	reset_n,
	enableReq,
	enableOut,
	gatedClk
);
	input wire clk;
	input wire reset_n;
	input wire enableReq;
	output reg enableOut;
	output wire gatedClk;

	reg enableLow_r;

	// The enable is taken on the rising edge and handed to the gate on the falling edge.
	always @(posedge clk) begin
		if (!reset_n) begin
			enableOut <= 1'b0;
		end else begin
			enableOut <= enableReq;
		end
	end

	// Changing the gate only while the clock is low keeps the gated clock free of runt pulses.
	always @(negedge clk) begin
		if (!reset_n) begin
			enableLow_r <= 1'b0;
		end else begin
			enableLow_r <= enableOut;
		end
	end

	assign gatedClk = clk & enableLow_r;
endmodule // unit_clock_gate

// ### design/deep_sleep_clock_gate.v
// Deep-sleep clock gating register with mode selection, bus fault detection and interrupt.
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/10ps
`include "deep_sleep_gate_consts.vh"

// Contract
// - Each writable bit is the clock enable of one unit, set means clocked and working, clear means stopped.
// - A read or write to a unit whose clock enable is clear is answered with a bus fault.
// - After reset every gating bit is zero so every unit starts unclocked.
// - This register's enables apply in deep sleep while companion registers govern run and sleep.
// - The sleep and deep-sleep registers are used only when automatic gating is selected, otherwise run gating applies.
// - Counter units 3, 2, 1 and 0 have their enables at bits 19, 18, 17 and 16, read/write, reset zero.
// - The synchronous serial unit 0 enable is at bit 4, read/write, reset zero.
// - The asynchronous serial units 1 and 0 have their enables at bits 1 and 0, read/write, reset zero.
// - Bits 31:27, 23:20, 15:5 and 3:2 are read-only, read zero and ignore writes.
// - Comparators 2, 1 and 0 have their enables at bits 26, 25 and 24, read/write, reset zero.
module deep_sleep_clock_gate (
	clk,
	reset_n,
	regAddr,
	regWrData,
	regWrStrobe,
	regRdStrobe,
	regRdData,
	runClockGate1,
	sleepClockGate1,
	autoSleepGatingSelect,
	sleepActive,
	deepSleepActive,
	unitAccess,
	unitAccessWrite,
	unitAccessIdx,
	busFault,
	unitClockEnable,
	unitGatedClk,
	irq
);
	input wire clk;
	input wire reset_n;
	input wire [`ADDR_W-1:0] regAddr;
	input wire [`DATA_W-1:0] regWrData;
	input wire regWrStrobe;
	input wire regRdStrobe;
	output reg [`DATA_W-1:0] regRdData;
	input wire [`DATA_W-1:0] runClockGate1;
	input wire [`DATA_W-1:0] sleepClockGate1;
	input wire autoSleepGatingSelect;
	input wire sleepActive;
	input wire deepSleepActive;
	input wire unitAccess;
	input wire unitAccessWrite;
	input wire [`UNIT_IDX_W-1:0] unitAccessIdx;
	output reg busFault;
	output wire [`UNIT_N-1:0] unitClockEnable;
	output wire [`UNIT_N-1:0] unitGatedClk;
	output wire irq;

	reg [`DATA_W-1:0] deepSleepClockGate1_r;
	reg [`IRQ_W-1:0] irqStatus_r;
	reg [`IRQ_W-1:0] irqStatus_nxt;
	reg [`IRQ_W-1:0] irqMask_r;
	reg [1:0] mode_r;
	reg [1:0] mode_nxt;
	reg [`UNIT_IDX_W-1:0] faultIdx_r;
	reg faultWrite_r;
	reg [`FAULT_COUNT_W-1:0] faultCount_r;
	reg [`DATA_W-1:0] selectedGate;
	reg [`DATA_W-1:0] readValue;
	wire [`UNIT_N-1:0] unitRequest;
	reg selEnable;
	wire faultNow;
	wire hitGate;
	wire hitStatus;
	wire hitMask;
	wire deepEnter;
	wire deepExit;
	wire gateWrite;
	wire maskWrite;
	wire statusRead;
	wire faultCountFull;
	wire [`DATA_W-1:0] gateWord;
	wire [`DATA_W-1:0] statusWord;
	wire [`DATA_W-1:0] maskWord;
	wire [`DATA_W-1:0] faultWord;
	wire reqAsyncSerial0;
	wire reqAsyncSerial1;
	wire reqSyncSerial0;
	wire reqGpCounter0;
	wire reqGpCounter1;
	wire reqGpCounter2;
	wire reqGpCounter3;
	wire reqComparator0;
	wire reqComparator1;
	wire reqComparator2;

	localparam MODE_RUN = `MODE_RUN;
	localparam MODE_SLEEP = `MODE_SLEEP;
	localparam MODE_DEEP = `MODE_DEEP;

	assign hitGate = (regAddr == `OFS_DEEP_SLEEP_GATE_1);
	assign hitStatus = (regAddr == `OFS_IRQ_STATUS);
	assign hitMask = (regAddr == `OFS_IRQ_MASK);

	// Strobes qualified by the decoded address.
	assign gateWrite = regWrStrobe && hitGate;
	assign maskWrite = regWrStrobe && hitMask;
	assign statusRead = regRdStrobe && hitStatus;

	// Only the documented enable bits take written data; reserved bits stay zero.
	always @(posedge clk) begin
		if (!reset_n) begin
			deepSleepClockGate1_r <= `DEEP_SLEEP_GATE_1_RESET;
		end else if (gateWrite) begin
			deepSleepClockGate1_r <= regWrData & `DEEP_SLEEP_GATE_1_WMASK;
		end
	end

	always @(posedge clk) begin
		if (!reset_n) begin
			irqMask_r <= `IRQ_MASK_RESET;
		end else if (maskWrite) begin
			irqMask_r <= regWrData[`IRQ_W-1:0];
		end
	end

	// Gating mode follows the power state only when automatic gating is selected.
	always @* begin
		mode_nxt = MODE_RUN;
		if (autoSleepGatingSelect) begin
			if (deepSleepActive) begin
				mode_nxt = MODE_DEEP;
			end else if (sleepActive) begin
				mode_nxt = MODE_SLEEP;
			end
		end
	end

	always @(posedge clk) begin
		if (!reset_n) begin
			mode_r <= MODE_RUN;
		end else begin
			mode_r <= mode_nxt;
		end
	end

	always @* begin
		case (mode_r)
			MODE_RUN: begin
				selectedGate = runClockGate1;
			end
			MODE_SLEEP: begin
				selectedGate = sleepClockGate1;
			end
			MODE_DEEP: begin
				selectedGate = deepSleepClockGate1_r;
			end
			default: begin
				selectedGate = runClockGate1;
			end
		endcase
	end

	assign deepEnter = (mode_nxt == MODE_DEEP) && (mode_r != MODE_DEEP);
	assign deepExit = (mode_nxt != MODE_DEEP) && (mode_r == MODE_DEEP);

	// Each unit takes its enable from its own bit of the selected word.
	assign reqAsyncSerial0 = selectedGate[`BIT_ASYNC_SERIAL_0];
	assign reqAsyncSerial1 = selectedGate[`BIT_ASYNC_SERIAL_1];
	assign reqSyncSerial0 = selectedGate[`BIT_SYNC_SERIAL_0];
	assign reqGpCounter0 = selectedGate[`BIT_GP_COUNTER_0];
	assign reqGpCounter1 = selectedGate[`BIT_GP_COUNTER_1];
	assign reqGpCounter2 = selectedGate[`BIT_GP_COUNTER_2];
	assign reqGpCounter3 = selectedGate[`BIT_GP_COUNTER_3];
	assign reqComparator0 = selectedGate[`BIT_COMPARATOR_0];
	assign reqComparator1 = selectedGate[`BIT_COMPARATOR_1];
	assign reqComparator2 = selectedGate[`BIT_COMPARATOR_2];

	// Unit order: async serial 0, 1, sync serial 0, counters 0 to 3, comparators 0 to 2.
	assign unitRequest = {
		reqComparator2,
		reqComparator1,
		reqComparator0,
		reqGpCounter3,
		reqGpCounter2,
		reqGpCounter1,
		reqGpCounter0,
		reqSyncSerial0,
		reqAsyncSerial1,
		reqAsyncSerial0
	};

	genvar g;
	generate
		for (g = 0; g < `UNIT_N; g = g + 1) begin : gateGen
			unit_clock_gate unit_clock_gate_inst (
				.clk(clk),
				.reset_n(reset_n),
				.enableReq(unitRequest[g]),
				.enableOut(unitClockEnable[g]),
				.gatedClk(unitGatedClk[g])
			);
		end
	endgenerate

	// An index beyond the unit count is treated as an unclocked unit.
	always @* begin
		selEnable = 1'b0;
		case (unitAccessIdx)
			4'h0: begin
				selEnable = unitClockEnable[0];
			end
			4'h1: begin
				selEnable = unitClockEnable[1];
			end
			4'h2: begin
				selEnable = unitClockEnable[2];
			end
			4'h3: begin
				selEnable = unitClockEnable[3];
			end
			4'h4: begin
				selEnable = unitClockEnable[4];
			end
			4'h5: begin
				selEnable = unitClockEnable[5];
			end
			4'h6: begin
				selEnable = unitClockEnable[6];
			end
			4'h7: begin
				selEnable = unitClockEnable[7];
			end
			4'h8: begin
				selEnable = unitClockEnable[8];
			end
			4'h9: begin
				selEnable = unitClockEnable[9];
			end
			default: begin
				selEnable = 1'b0;
			end
		endcase
	end
	assign faultNow = unitAccess && !selEnable;

	// Fault capture keeps the last faulting unit and a saturating count.
	assign faultCountFull = (faultCount_r == {`FAULT_COUNT_W{1'b1}});

	always @(posedge clk) begin
		if (!reset_n) begin
			busFault <= 1'b0;
		end else begin
			busFault <= faultNow;
		end
	end

	always @(posedge clk) begin
		if (!reset_n) begin
			faultIdx_r <= {`UNIT_IDX_W{1'b0}};
			faultWrite_r <= 1'b0;
		end else if (faultNow) begin
			faultIdx_r <= unitAccessIdx;
			faultWrite_r <= unitAccessWrite;
		end
	end

	always @(posedge clk) begin
		if (!reset_n) begin
			faultCount_r <= {`FAULT_COUNT_W{1'b0}};
		end else if (faultNow && !faultCountFull) begin
			faultCount_r <= faultCount_r + 1'b1;
		end
	end

	// A status read clears the bits, but an event in the same cycle still sets its bit.
	always @* begin
		irqStatus_nxt = irqStatus_r;
		if (statusRead) begin
			irqStatus_nxt = `IRQ_STATUS_RESET;
		end
		if (faultNow) begin
			irqStatus_nxt[`IRQ_BUS_FAULT] = 1'b1;
		end
		if (deepEnter) begin
			irqStatus_nxt[`IRQ_DEEP_ENTER] = 1'b1;
		end
		if (deepExit) begin
			irqStatus_nxt[`IRQ_DEEP_EXIT] = 1'b1;
		end
	end

	always @(posedge clk) begin
		if (!reset_n) begin
			irqStatus_r <= `IRQ_STATUS_RESET;
		end else begin
			irqStatus_r <= irqStatus_nxt;
		end
	end

	assign irq = |(irqStatus_r & irqMask_r);

	// Readable words; status, mask and fault words are padded with zeros to the bus width.
	assign gateWord = deepSleepClockGate1_r;
	assign statusWord = {{(`DATA_W-`IRQ_W){1'b0}}, irqStatus_r};
	assign maskWord = {{(`DATA_W-`IRQ_W){1'b0}}, irqMask_r};
	assign faultWord = {
		{(`DATA_W-`FAULT_WRITE_BIT-1){1'b0}},
		faultWrite_r,
		faultCount_r,
		{(`FAULT_COUNT_LSB-`UNIT_IDX_W){1'b0}},
		faultIdx_r
	};

	always @* begin
		readValue = `READ_ZERO;
		case (regAddr)
			`OFS_DEEP_SLEEP_GATE_1: begin
				readValue = gateWord;
			end
			`OFS_IRQ_STATUS: begin
				readValue = statusWord;
			end
			`OFS_IRQ_MASK: begin
				readValue = maskWord;
			end
			`OFS_FAULT_INFO: begin
				readValue = faultWord;
			end
			default: begin
				readValue = `READ_ZERO;
			end
		endcase
	end

	// Read data stands only in the cycle after the read strobe.
	always @(posedge clk) begin
		if (!reset_n) begin
			regRdData <= `READ_ZERO;
		end else if (regRdStrobe) begin
			regRdData <= readValue;
		end else begin
			regRdData <= `READ_ZERO;
		end
	end
endmodule // deep_sleep_clock_gate

// ### test/deep_sleep_clock_gate_checker.sv
// Assertion checker for the deep-sleep clock gating block.
`timescale 1ns/10ps
`include "deep_sleep_gate_consts.vh"
module deep_sleep_clock_gate_checker (
	input wire clk,
	input wire reset_n,
	input wire [`ADDR_W-1:0] regAddr,
	input wire regWrStrobe,
	input wire regRdStrobe,
	input wire [`DATA_W-1:0] regRdData,
	input wire [`DATA_W-1:0] runClockGate1,
	input wire [`DATA_W-1:0] sleepClockGate1,
	input wire autoSleepGatingSelect,
	input wire sleepActive,
	input wire deepSleepActive,
	input wire unitAccess,
	input wire [`UNIT_IDX_W-1:0] unitAccessIdx,
	input wire busFault,
	input wire [`UNIT_N-1:0] unitClockEnable
);
	function [9:0] pick(input [31:0] v);
		pick = {v[26:24], v[19:16], v[4], v[1:0]};
	endfunction
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	reset_clear_a: assert property ($rose(reset_n) |-> unitClockEnable == 0 && regRdData == 0 && !busFault)
		else $error("outputs not clear after reset");
	res_bits_a: assert property (regRdStrobe && regAddr == `OFS_DEEP_SLEEP_GATE_1 |=> (regRdData & ~32'h070f0013) == 0)
		else $error("reserved gate bits read nonzero");
	rd_idle_a: assert property (!regRdStrobe |=> regRdData == 0)
		else $error("read data outside read slot");
	fault_on_a: assert property (unitAccess && unitAccessIdx < 10 && !unitClockEnable[unitAccessIdx] |=> busFault)
		else $error("gated unit access not faulted");
	fault_off_a: assert property (unitAccess && unitAccessIdx < 10 && unitClockEnable[unitAccessIdx] |=> !busFault)
		else $error("clocked unit access faulted");
	bad_idx_a: assert property (unitAccess && unitAccessIdx > 4'h9 |=> busFault)
		else $error("unknown unit access not faulted");
	no_access_a: assert property (!unitAccess |=> !busFault)
		else $error("fault without access");
	run_sel_a: assert property ((!autoSleepGatingSelect && $stable(runClockGate1))[*3] |-> ##1
		unitClockEnable == pick($past(runClockGate1))) else $error("run word not applied");
	sleep_sel_a: assert property ((autoSleepGatingSelect && sleepActive && !deepSleepActive && $stable(sleepClockGate1))[*3]
		|-> ##1 unitClockEnable == pick($past(sleepClockGate1))) else $error("sleep word not applied");
	hold_en_a: assert property (($past(reset_n) && !regWrStrobe && $stable({runClockGate1, sleepClockGate1,
		autoSleepGatingSelect, sleepActive, deepSleepActive}))[*2] |=> $stable(unitClockEnable))
		else $error("enables moved without cause");
	cover property (unitAccess ##1 busFault);
	cover property (autoSleepGatingSelect && deepSleepActive ##3 unitClockEnable != 0);
	cover property (regRdStrobe && regAddr == `OFS_DEEP_SLEEP_GATE_1 ##1 regRdData != 0);
endmodule // deep_sleep_clock_gate_checker
bind deep_sleep_clock_gate deep_sleep_clock_gate_checker deep_sleep_clock_gate_checker_inst (.clk(clk), .reset_n(reset_n),
	.regAddr(regAddr), .regWrStrobe(regWrStrobe), .regRdStrobe(regRdStrobe), .regRdData(regRdData),
	.runClockGate1(runClockGate1), .sleepClockGate1(sleepClockGate1), .autoSleepGatingSelect(autoSleepGatingSelect),
	.sleepActive(sleepActive), .deepSleepActive(deepSleepActive), .unitAccess(unitAccess),
	.unitAccessIdx(unitAccessIdx), .busFault(busFault), .unitClockEnable(unitClockEnable));

// ### test/deep_sleep_clock_gate_tb_top.sv
// Self-checking testbench for the deep-sleep clock gating block.
`timescale 1ns/10ps
`include "deep_sleep_gate_consts.vh"
module deep_sleep_clock_gate_tb_top;
	logic clk, reset_n, regWrStrobe, regRdStrobe, autoSleepGatingSelect, sleepActive, deepSleepActive;
	logic unitAccess, unitAccessWrite, busFault, irq, rdSeen, fltSeen, lastWr;
	logic [11:0] regAddr;
	logic [31:0] regWrData, regRdData, runClockGate1, sleepClockGate1, w;
	logic [3:0] unitAccessIdx;
	logic [9:0] unitClockEnable, unitGatedClk;
	logic [32:0] ent;
	logic [32:0] rdQ[$];
	logic fltQ[$];
	int err_count = 0, check_count = 0, seed = 32'hcbeb226f, i;
	int pos[10] = '{0, 1, 4, 16, 17, 18, 19, 24, 25, 26};
	deep_sleep_clock_gate deep_sleep_clock_gate_inst (.clk(clk), .reset_n(reset_n), .regAddr(regAddr),
		.regWrData(regWrData), .regWrStrobe(regWrStrobe), .regRdStrobe(regRdStrobe), .regRdData(regRdData),
		.runClockGate1(runClockGate1), .sleepClockGate1(sleepClockGate1), .autoSleepGatingSelect(autoSleepGatingSelect),
		.sleepActive(sleepActive), .deepSleepActive(deepSleepActive), .unitAccess(unitAccess),
		.unitAccessWrite(unitAccessWrite), .unitAccessIdx(unitAccessIdx), .busFault(busFault),
		.unitClockEnable(unitClockEnable), .unitGatedClk(unitGatedClk), .irq(irq));
	initial begin
		clk = 0;
		forever #50 clk = ~clk;
	end
	task chk(input [31:0] g, input [31:0] e);
		check_count++;
		if (g !== e) begin
			err_count++;
			$display("BAD %0t got %h want %h", $time, g, e);
		end
	endtask
	task end_sim;
		$display("checks %0d errors %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task bus(input logic wrt, input [11:0] a, input [31:0] d, input logic c);
		regWrStrobe <= wrt;
		regRdStrobe <= !wrt;
		regAddr <= a;
		regWrData <= d;
		if (!wrt) rdQ.push_back({c, d});
		@(posedge clk);
	endtask
	task acc(input [3:0] x, input logic f);
		unitAccess <= 1;
		unitAccessIdx <= x;
		lastWr = $random(seed);
		unitAccessWrite <= lastWr;
		fltQ.push_back(f);
		@(posedge clk);
	endtask
	task idle;
		regWrStrobe <= 0;
		regRdStrobe <= 0;
		unitAccess <= 0;
		@(posedge clk);
	endtask
	task mode(input logic a, input logic s, input logic d, input [9:0] e);
		autoSleepGatingSelect <= a;
		sleepActive <= s;
		deepSleepActive <= d;
		repeat (3) @(posedge clk);
		#1 chk(unitClockEnable, e);
		chk(unitGatedClk, e);
		@(posedge clk);
	endtask
	always @(posedge clk) begin
		rdSeen <= regRdStrobe;
		fltSeen <= unitAccess;
		if (rdSeen) begin
			ent = rdQ.pop_front();
			if (ent[32]) chk(regRdData, ent[31:0]);
		end
		if (fltSeen) chk(busFault, fltQ.pop_front());
	end
	initial begin
		{regWrStrobe, regRdStrobe, unitAccess, unitAccessWrite, rdSeen, fltSeen, reset_n} = 0;
		{autoSleepGatingSelect, sleepActive, deepSleepActive, unitAccessIdx, regAddr} = 0;
		{regWrData, runClockGate1, sleepClockGate1} = 0;
		repeat (10) @(posedge clk);
		reset_n <= 1;
		@(posedge clk);
		bus(0, `OFS_DEEP_SLEEP_GATE_1, 32'h0, 1);
		bus(0, 12'h200, 32'h0, 1);
		bus(1, `OFS_DEEP_SLEEP_GATE_1, 32'hffffffff, 0);
		bus(0, `OFS_DEEP_SLEEP_GATE_1, 32'h070f0013, 1);
		for (i = 0; i < 8; i++) begin
			w = $random(seed);
			bus(1, `OFS_DEEP_SLEEP_GATE_1, w, 0);
			bus(0, `OFS_DEEP_SLEEP_GATE_1, w & 32'h070f0013, 1);
		end
		bus(1, `OFS_DEEP_SLEEP_GATE_1, (w & 32'h070f0013) | 32'h10, 0);
		bus(0, `OFS_DEEP_SLEEP_GATE_1, (w & 32'h070f0013) | 32'h10, 1);
		idle;
		$display("test registers done");
		for (i = 0; i < 10; i++) begin
			bus(1, `OFS_DEEP_SLEEP_GATE_1, 32'h1 << pos[i], 0);
			idle;
			mode(1, i[0], 1, 10'h1 << i);
			acc(i, 0);
			acc((i + 1) % 10, 1);
			acc(4'hf, 1);
			idle;
		end
		$display("test unit gating done");
		bus(0, `OFS_IRQ_STATUS, 32'h0, 0);
		bus(1, `OFS_IRQ_MASK, 32'h1, 0);
		acc(5, 1);
		idle;
		#1 chk(irq, 1);
		@(posedge clk);
		bus(0, `OFS_FAULT_INFO, {15'h0, lastWr, 8'h15, 8'h05}, 1);
		bus(1, `OFS_IRQ_MASK, 32'h0, 0);
		idle;
		#1 chk(irq, 0);
		@(posedge clk);
		bus(1, `OFS_IRQ_MASK, 32'h1, 0);
		bus(0, `OFS_IRQ_STATUS, 32'h1, 1);
		idle;
		#1 chk(irq, 0);
		$display("test interrupt done");
		w = $random(seed);
		runClockGate1 <= w;
		sleepClockGate1 <= ~w;
		mode(0, 0, 1, {w[26:24], w[19:16], w[4], w[1:0]});
		mode(1, 1, 0, ~{w[26:24], w[19:16], w[4], w[1:0]});
		mode(0, 1, 0, {w[26:24], w[19:16], w[4], w[1:0]});
		$display("test modes done");
		end_sim;
	end
	initial begin
		#300000;
		err_count++;
		end_sim;
	end
endmodule // deep_sleep_clock_gate_tb_top
